/* File: rtl/odt_pkg.sv */
// constants, types and register map of the on/off delay timer
`default_nettype none
package odt_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 20;
  localparam int DLY_W = 26;
  localparam int ADDR_W = 8;
  localparam int TB_W = 2;
  localparam int BLK_W = 8;
  localparam int FLD_W = 8;
  localparam int KIND_W = 4;
  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PARAM_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] ELAPSED_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] DELAY_OFS = 8'h10;
  // field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_RET_BIT = 1;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_TB_LSB = 4;
  localparam int CTRL_BLK_LSB = 8;
  localparam int PARAM_LO_LSB = 0;
  localparam int PARAM_HI_LSB = 8;
  localparam int STAT_Q_BIT = 0;
  localparam int STAT_TRIG_BIT = 1;
  localparam int STAT_RUN_BIT = 2;
  // reset values
  localparam logic [FLD_W-1:0] RST_PAR_HI = 8'h00;
  localparam logic [FLD_W-1:0] RST_PAR_LO = 8'h00;
  localparam logic [BLK_W-1:0] RST_BLK = 8'h00;
  // bus codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] RD_ZERO = 32'h0;
  // delay limits and scales
  localparam logic [31:0] PAR_HI_MAX = 32'h63;
  localparam logic [31:0] SEC_LO_MAX = 32'h63;
  localparam logic [31:0] MIN_LO_MAX = 32'h3b;
  localparam logic [31:0] UNITS_PER_NEXT = 32'h3c;
  localparam logic [31:0] TICKS_PER_S = 32'h64;
  localparam logic [31:0] TICKS_PER_MIN = 32'h1770;
  localparam logic [31:0] TICK_MS = 32'ha;
  localparam logic [31:0] BLK_MS_MAX = 32'h18696;
  localparam logic [31:0] BLK_S_MAX = 32'h176f;
  localparam logic [31:0] BLK_M_MAX = 32'h176f;
  localparam logic [DLY_W-1:0] DLY_MAX = 26'h2253990;
  // timebases: fine = s or ms, mid = m or s, coarse = h or m
  typedef enum logic [TB_W-1:0] {
    ODT_TB_FINE = 2'h0,
    ODT_TB_MID = 2'h1,
    ODT_TB_COARSE = 2'h2
  } odt_tbase_type;
  // kinds of referenced blocks
  typedef enum logic [KIND_W-1:0] {
    ODT_SRC_NONE = 4'h0,
    ODT_SRC_CMP = 4'h1,
    ODT_SRC_THR = 4'h2,
    ODT_SRC_AMP = 4'h3,
    ODT_SRC_MUX = 4'h4,
    ODT_SRC_RAMP = 4'h5,
    ODT_SRC_MATH = 4'h6,
    ODT_SRC_PI = 4'h7,
    ODT_SRC_CNT = 4'h8
  } odt_kind_type;
  // timer states, gray along idle, run, done
  typedef enum logic [1:0] {
    ODT_IDLE = 2'b00,
    ODT_RUN = 2'b01,
    ODT_DONE = 2'b11
  } odt_st_type;
endpackage : odt_pkg
`default_nettype wire

/* File: rtl/odt_delay_calc.sv */
// delay in ticks from parameter or referenced block value
`default_nettype none
module odt_delay_calc
  import odt_pkg::*;
(
  // configuration
  input wire logic src_blk,
  input wire logic [TB_W-1:0] tbase,
  input wire logic [FLD_W-1:0] par_hi,
  input wire logic [FLD_W-1:0] par_lo,
  // referenced block
  input wire logic [KIND_W-1:0] src_kind,
  input wire logic [31:0] src_value,
  // result
  output logic [DLY_W-1:0] delay_ticks
);
  logic [31:0] hi;
  logic [31:0] lo;
  logic [31:0] val;
  logic [31:0] ticks;
  logic allowed;

  always_comb
  begin
    hi = (32'(par_hi) > PAR_HI_MAX) ? PAR_HI_MAX : 32'(par_hi);
    lo = 32'(par_lo);
    val = src_value[31] ? RD_ZERO : src_value;
    allowed = src_kind inside {ODT_SRC_CMP, ODT_SRC_THR, ODT_SRC_AMP, ODT_SRC_MUX,
                               ODT_SRC_RAMP, ODT_SRC_MATH, ODT_SRC_PI, ODT_SRC_CNT};
    if (src_blk && allowed)
    begin
      case (tbase)
        ODT_TB_MID: ticks = ((val > BLK_S_MAX) ? BLK_S_MAX : val) * TICKS_PER_S;
        ODT_TB_COARSE: ticks = ((val > BLK_M_MAX) ? BLK_M_MAX : val) * TICKS_PER_MIN;
        default: ticks = ((val > BLK_MS_MAX) ? BLK_MS_MAX : val) / TICK_MS;
      endcase
    end
    else
    begin
      case (tbase)
        ODT_TB_MID:
        begin
          lo = (lo > MIN_LO_MAX) ? MIN_LO_MAX : lo;
          ticks = (hi * UNITS_PER_NEXT + lo) * TICKS_PER_S;
        end
        ODT_TB_COARSE:
        begin
          lo = (lo > MIN_LO_MAX) ? MIN_LO_MAX : lo;
          ticks = (hi * UNITS_PER_NEXT + lo) * TICKS_PER_MIN;
        end
        default:
        begin
          lo = (lo > SEC_LO_MAX) ? SEC_LO_MAX : lo;
          ticks = hi * TICKS_PER_S + lo;
        end
      endcase
    end
    delay_ticks = ticks[DLY_W-1:0];
  end
endmodule : odt_delay_calc
`default_nettype wire

/* File: rtl/odt_timer.sv */
// on/off delay timer function block with ahb-lite registers
`default_nettype none
module odt_timer
  import odt_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // function block inputs
  input wire logic trig_in,
  input wire logic clear_in,
  input wire logic power_fail,
  // referenced block
  input wire logic [KIND_W-1:0] src_kind,
  input wire logic [31:0] src_value,
  output logic [BLK_W-1:0] src_block_num,
  // function block output
  output logic timer_out
);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic mode_off;
    logic retain;
    logic src_blk;
    logic [TB_W-1:0] tbase;
    logic [BLK_W-1:0] blk_num;
    logic [FLD_W-1:0] par_hi;
    logic [FLD_W-1:0] par_lo;
    odt_st_type st;
    logic q;
    logic trig_prev;
    logic [DLY_W-1:0] elapsed;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
  } odt_state_type;

  odt_state_type s_reg;
  odt_state_type s_next;
  logic [DLY_W-1:0] delay_ticks;
  logic rise;
  logic fall;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic reached;

  ////////////////////////////////////////////////////////////////////////////
  // delay source
  odt_delay_calc u_calc (
    .src_blk(s_reg.src_blk),
    .tbase(s_reg.tbase),
    .par_hi(s_reg.par_hi),
    .par_lo(s_reg.par_lo),
    .src_kind(src_kind),
    .src_value(src_value),
    .delay_ticks(delay_ticks)
  );

  assign rise = trig_in && !s_reg.trig_prev;
  assign fall = !trig_in && s_reg.trig_prev;
  assign reached = s_reg.elapsed >= delay_ticks;
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign timer_out = s_reg.q;
  assign src_block_num = s_reg.blk_num;

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    rd_mux = RD_ZERO;
    case (haddr[ADDR_W-1:0])
      CTRL_OFS:
      begin
        rd_mux[CTRL_MODE_BIT] = s_reg.mode_off;
        rd_mux[CTRL_RET_BIT] = s_reg.retain;
        rd_mux[CTRL_SRC_BIT] = s_reg.src_blk;
        rd_mux[CTRL_TB_LSB +: TB_W] = s_reg.tbase;
        rd_mux[CTRL_BLK_LSB +: BLK_W] = s_reg.blk_num;
      end
      PARAM_OFS:
      begin
        rd_mux[PARAM_LO_LSB +: FLD_W] = s_reg.par_lo;
        rd_mux[PARAM_HI_LSB +: FLD_W] = s_reg.par_hi;
      end
      STATUS_OFS:
      begin
        rd_mux[STAT_Q_BIT] = s_reg.q;
        rd_mux[STAT_TRIG_BIT] = trig_in;
        rd_mux[STAT_RUN_BIT] = (s_reg.st == ODT_RUN);
      end
      ELAPSED_OFS: rd_mux = 32'(s_reg.elapsed);
      DELAY_OFS: rd_mux = 32'(delay_ticks);
      default: rd_mux = RD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_next = s_reg;
    // tick generator
    s_next.tick = 1'b0;
    if (s_reg.tick_cnt == TICK_LAST)
    begin
      s_next.tick_cnt = '0;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
    end
    s_next.trig_prev = trig_in;
    // timer
    if (power_fail)
    begin
      s_next.trig_prev = 1'b0;
      if (!s_reg.retain)
      begin
        s_next.q = 1'b0;
        s_next.elapsed = '0;
        s_next.st = ODT_IDLE;
      end
      else
      begin
        s_next.trig_prev = s_reg.trig_prev;
      end
    end
    else if (!s_reg.mode_off)
    begin
      if (!trig_in)
      begin
        s_next.q = 1'b0;
        s_next.elapsed = '0;
        s_next.st = ODT_IDLE;
      end
      else if (rise)
      begin
        s_next.elapsed = '0;
        s_next.q = 1'b0;
        s_next.st = ODT_RUN;
      end
      else if (s_reg.st == ODT_RUN)
      begin
        if (reached)
        begin
          s_next.q = 1'b1;
          s_next.st = ODT_DONE;
        end
        else if (s_reg.tick)
        begin
          s_next.elapsed = s_reg.elapsed + 1'b1;
        end
      end
    end
    else
    begin
      if (clear_in)
      begin
        s_next.q = 1'b0;
        s_next.elapsed = '0;
        s_next.st = ODT_IDLE;
      end
      else if (trig_in)
      begin
        s_next.q = 1'b1;
        s_next.elapsed = '0;
        s_next.st = ODT_IDLE;
      end
      else if (fall)
      begin
        s_next.elapsed = '0;
        s_next.st = ODT_RUN;
      end
      else if (s_reg.st == ODT_RUN)
      begin
        if (reached)
        begin
          s_next.q = 1'b0;
          s_next.st = ODT_DONE;
        end
        else if (s_reg.tick)
        begin
          s_next.elapsed = s_reg.elapsed + 1'b1;
        end
      end
    end
    // bus address phase
    if (hready)
    begin
      s_next.wr_pend = addr_ok && hwrite && (hsize == HSIZE_WORD);
      s_next.wr_addr = haddr[ADDR_W-1:0];
      if (addr_ok && !hwrite)
      begin
        s_next.rdata = rd_mux;
      end
    end
    // bus data phase write
    if (s_reg.wr_pend)
    begin
      case (s_reg.wr_addr)
        CTRL_OFS:
        begin
          s_next.mode_off = hwdata[CTRL_MODE_BIT];
          s_next.retain = hwdata[CTRL_RET_BIT];
          s_next.src_blk = hwdata[CTRL_SRC_BIT];
          s_next.tbase = hwdata[CTRL_TB_LSB +: TB_W];
          s_next.blk_num = hwdata[CTRL_BLK_LSB +: BLK_W];
          // reconfiguration restarts the function
          s_next.q = 1'b0;
          s_next.elapsed = '0;
          s_next.st = ODT_IDLE;
          s_next.trig_prev = 1'b0;
        end
        PARAM_OFS:
        begin
          s_next.par_lo = hwdata[PARAM_LO_LSB +: FLD_W];
          s_next.par_hi = hwdata[PARAM_HI_LSB +: FLD_W];
        end
        default: s_next.wr_pend = 1'b0;
      endcase
      s_next.wr_pend = 1'b0;
      if (hready)
      begin
        s_next.wr_pend = addr_ok && hwrite && (hsize == HSIZE_WORD);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= '{mode_off: 1'b0, retain: 1'b0, src_blk: 1'b0, tbase: ODT_TB_FINE,
                 blk_num: RST_BLK, par_hi: RST_PAR_HI, par_lo: RST_PAR_LO, st: ODT_IDLE,
                 q: 1'b0, trig_prev: 1'b0, elapsed: '0, tick_cnt: '0, tick: 1'b0,
                 wr_pend: 1'b0, wr_addr: '0, rdata: RD_ZERO};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  on_start_a: assert property (!s_reg.mode_off && rise && !power_fail && !s_reg.wr_pend
    |=> s_reg.elapsed == '0 && s_reg.st == ODT_RUN && !s_reg.q)
    else $error("on-delay start did not clear elapsed");
  on_set_a: assert property (!s_reg.mode_off && s_reg.st == ODT_RUN && reached && trig_in
    && !rise && !power_fail && !s_reg.wr_pend |=> s_reg.q)
    else $error("on-delay output not set at delay");
  on_drop_a: assert property (!s_reg.mode_off && !trig_in && !power_fail
    |=> !s_reg.q && s_reg.elapsed == '0)
    else $error("on-delay early fall not cleared");
  on_low_a: assert property (!s_reg.mode_off && s_reg.q && !$past(power_fail) |-> $past(trig_in))
    else $error("on-delay output high with low trigger");
  power_loss_a: assert property (power_fail && !s_reg.retain && !s_reg.wr_pend
    |=> !s_reg.q && s_reg.elapsed == '0)
    else $error("state kept over power fail without retention");
  power_keep_a: assert property (power_fail && s_reg.retain && !s_reg.wr_pend
    |=> s_reg.q == $past(s_reg.q) && s_reg.elapsed == $past(s_reg.elapsed))
    else $error("retentive state lost over power fail");
  delay_clamp_a: assert property (delay_ticks <= DLY_MAX)
    else $error("delay beyond largest valid value");
  off_fall_a: assert property (s_reg.mode_off && fall && !clear_in && !power_fail
    && !s_reg.wr_pend |=> s_reg.elapsed == '0 && s_reg.st == ODT_RUN && s_reg.q == $past(s_reg.q))
    else $error("off-delay fall did not restart count");
  off_clear_a: assert property (s_reg.mode_off && clear_in && !power_fail
    |=> !s_reg.q && s_reg.elapsed == '0)
    else $error("off-delay clear ignored");
  off_rise_a: assert property (s_reg.mode_off && trig_in && !clear_in && !power_fail
    && !s_reg.wr_pend |=> s_reg.q)
    else $error("off-delay output not set by trigger");
  off_expire_a: assert property (s_reg.mode_off && s_reg.st == ODT_RUN && reached && !trig_in
    && !fall && !clear_in && !power_fail && !s_reg.wr_pend |=> !s_reg.q)
    else $error("off-delay output not released at delay");
  tick_step_a: assert property (s_reg.elapsed != $past(s_reg.elapsed) && s_reg.elapsed != '0
    |-> $past(s_reg.tick) && s_reg.elapsed == $past(s_reg.elapsed) + 1'b1)
    else $error("elapsed moved without tick");
endmodule : odt_timer
`default_nettype wire

/* File: bench/odt_src_model.sv */
// referenced function block model for the delay timer
`default_nettype none
module odt_src_model
  import odt_pkg::*;
(
  // selection
  input wire logic [BLK_W-1:0] src_block_num,
  input wire logic [31:0] blk_value,
  // live value
  output logic [KIND_W-1:0] src_kind,
  output logic [31:0] src_value
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // block n is of kind n mod 16, no usable kind where n mod 16 is 0 or above 8
  assign src_kind = src_block_num[KIND_W-1:0];
  assign src_value = blk_value;
endmodule : odt_src_model
`default_nettype wire

/* File: bench/on_off_delay_timer_tb.sv */
// self-checking testbench of the on/off delay timer
`default_nettype none
module on_off_delay_timer_tb
  import odt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TCYC = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic trig_in = 1'b0;
  logic clear_in = 1'b0;
  logic power_fail = 1'b0;
  logic [31:0] blk_value = 32'h0;
  logic hreadyout;
  logic hresp;
  logic timer_out;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [KIND_W-1:0] src_kind;
  logic [31:0] src_value;
  logic [BLK_W-1:0] src_block_num;
  int num_errors = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////
  always #5 hclk = ~hclk;
  odt_timer #(.TICK_CYCLES(TCYC)) DUT (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .trig_in(trig_in),
    .clear_in(clear_in),
    .power_fail(power_fail),
    .src_kind(src_kind),
    .src_value(src_value),
    .src_block_num(src_block_num),
    .timer_out(timer_out)
  );
  odt_src_model src_model (
    .src_block_num(src_block_num),
    .blk_value(blk_value),
    .src_kind(src_kind),
    .src_value(src_value)
  );
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, HSIZE_WORD);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, HSIZE_WORD);
    chk(rd, e);
    chk(hresp, 32'h0);
    chk(hreadyout, 32'h1);
  endtask : rdc
  task automatic drive(input logic t, input logic c, input logic p);
    @(posedge hclk);
    trig_in <= t;
    clear_in <= c;
    power_fail <= p;
  endtask : drive
  task automatic ochk(input int n, input logic e);
    repeat (n) @(posedge hclk);
    #1;
    chk(timer_out, e);
  endtask : ochk
  task automatic dcase(input logic [31:0] ctl, input logic [31:0] par, input logic [31:0] v, input logic [31:0] e);
    blk_value <= v;
    wr(PARAM_OFS, par);
    wr(CTRL_OFS, ctl);
    rdc(DELAY_OFS, e);
    chk(src_block_num, ctl[15:8]);
  endtask : dcase
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    wr(STATUS_OFS, 32'hff);
    wr(32'h20, 32'hff);
    xfer(PARAM_OFS, 1'b1, 32'h55, 3'h0);
    for (int a = 0; a <= 32; a += 4)
      rdc(a, 32'h0);
    chk(timer_out, 32'h0);
  endtask : t_reset
  task automatic t_delay();
    dcase(32'h0, 32'h040a, 32'h0, 32'd410);
    dcase(32'h0, 32'h6378, 32'h0, 32'd9999);
    dcase(32'h10, 32'h040a, 32'h0, 32'd25000);
    dcase(32'h10, 32'h0a50, 32'h0, 32'd65900);
    dcase(32'h20, 32'h040a, 32'h0, 32'd1500000);
    dcase(32'h20, 32'h633b, 32'h0, 32'd35994000);
    dcase(32'h0104, 32'h3, 32'd12345, 32'd1234);
    dcase(32'h0204, 32'h3, 32'd200000, 32'd9999);
    dcase(32'h0304, 32'h3, 32'hffff_fffb, 32'h0);
    dcase(32'h0414, 32'h3, 32'd7000, 32'd599900);
    dcase(32'h0514, 32'h3, 32'd20, 32'd2000);
    dcase(32'h0624, 32'h3, 32'd10, 32'd60000);
    dcase(32'h0724, 32'h3, 32'd6000, 32'd35994000);
    dcase(32'h0804, 32'h3, 32'd50, 32'd5);
    dcase(32'h0904, 32'h3, 32'd50, 32'd3);
    dcase(32'h0805, 32'h3, 32'd50, 32'd5);
  endtask : t_delay
  task automatic t_on();
    wr(PARAM_OFS, 32'h3);
    wr(CTRL_OFS, 32'h0);
    drive(1'b1, 1'b0, 1'b0);
    ochk(8, 1'b0);
    ochk(9, 1'b1);
    drive(1'b0, 1'b0, 1'b0);
    ochk(2, 1'b0);
    drive(1'b1, 1'b0, 1'b0);
    ochk(6, 1'b0);
    drive(1'b0, 1'b1, 1'b0);
    ochk(2, 1'b0);
    rdc(ELAPSED_OFS, 32'h0);
    drive(1'b1, 1'b0, 1'b0);
    ochk(8, 1'b0);
    ochk(9, 1'b1);
    rdc(STATUS_OFS, 32'h3);
  endtask : t_on
  task automatic t_pf();
    drive(1'b1, 1'b0, 1'b1);
    ochk(2, 1'b0);
    rdc(ELAPSED_OFS, 32'h0);
    drive(1'b0, 1'b0, 1'b0);
    wr(CTRL_OFS, 32'h2);
    drive(1'b1, 1'b0, 1'b0);
    ochk(6, 1'b0);
    drive(1'b1, 1'b0, 1'b1);
    ochk(20, 1'b0);
    rdc(STATUS_OFS, 32'h6);
    drive(1'b1, 1'b0, 1'b0);
    ochk(17, 1'b1);
    drive(1'b1, 1'b0, 1'b1);
    ochk(4, 1'b1);
    drive(1'b0, 1'b0, 1'b0);
  endtask : t_pf
  task automatic t_off();
    wr(CTRL_OFS, 32'h1);
    drive(1'b1, 1'b0, 1'b0);
    ochk(2, 1'b1);
    drive(1'b0, 1'b0, 1'b0);
    ochk(8, 1'b1);
    drive(1'b1, 1'b0, 1'b0);
    drive(1'b0, 1'b0, 1'b0);
    ochk(8, 1'b1);
    ochk(9, 1'b0);
    drive(1'b1, 1'b0, 1'b0);
    ochk(2, 1'b1);
    drive(1'b0, 1'b0, 1'b0);
    drive(1'b0, 1'b1, 1'b0);
    ochk(2, 1'b0);
    rdc(ELAPSED_OFS, 32'h0);
    drive(1'b0, 1'b0, 1'b0);
  endtask : t_off
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_delay();
    t_on();
    t_pf();
    t_off();
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    print_verdict();
  end
endmodule : on_off_delay_timer_tb
`default_nettype wire
